/* File: vrc_regs.svh */
// Offsets, field positions, reset values and timing counts of the relay control link
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH

// Relay drive bytes on the link, byte offsets from the module base
`define VRC_RLY0_OFS 4'h1
`define VRC_RLY1_OFS 4'h3
`define VRC_RLY2_OFS 4'h5
`define VRC_RLY3_OFS 4'h7
`define VRC_RLY_RST 8'h00

// Command word: opcode in the high byte, argument in the low byte
`define VRC_OPC_MSB 15
`define VRC_OPC_LSB 8
`define VRC_OPC_BEGIN_NORMAL 8'hA1
`define VRC_OPC_ABORT_NORMAL 8'hA2
`define VRC_OPC_END_NORMAL 8'hA3
`define VRC_OPC_ASSIGN_INT 8'hA4
`define VRC_OPC_ASCII 8'hA5
`define VRC_LVL_RST 3'h0

// Relay settling time and its cycle count at 200 MHz (least time, rounded up)
`define VRC_SETTLE_NS 1000
`define VRC_CLK_MHZ 200
`define VRC_SETTLE_CYC ((`VRC_SETTLE_NS * `VRC_CLK_MHZ + 999) / 1000)

// Host controller APB map
`define VRC_APB_OP 8'h00
`define VRC_APB_STAT 8'h04
`define VRC_APB_ISTAT 8'h08
`define VRC_APB_IMASK 8'h0C
`define VRC_APB_IMG 8'h10
`define VRC_OP_KIND_LSB 0
`define VRC_OP_IDX_LSB 2
`define VRC_OP_AND_LSB 8
`define VRC_OP_OR_LSB 16
`define VRC_OP_CMD_LSB 16
`define VRC_IRQ_DONE 0
`define VRC_IRQ_REFUSED 1
`define VRC_IRQ_DEV 2
`define VRC_IMASK_RST 3'h0

`endif

/* File: vrc_pkg.sv */
// Types shared by both ends of the relay control link
package vrc_pkg;
    // Kind of transfer on the link
    typedef enum logic [1:0] {
        VRC_K_WRITE = 2'b00,
        VRC_K_READ = 2'b01,
        VRC_K_CMD = 2'b10
    } vrc_kind_t;

    // Host controller sequencer
    typedef enum logic [1:0] {
        VRC_H_IDLE = 2'b00,
        VRC_H_BUSY = 2'b01
    } vrc_hstate_t;
endpackage

/* File: vrc_link_if.sv */
// Link between the host controller and the relay control device
`timescale 1ns/10ps
`default_nettype none
interface vrc_link_if;
    logic req; // Request held until ack
    vrc_pkg::vrc_kind_t kind; // Write, read or command
    logic [3:0] addr; // Byte offset from module base
    logic [15:0] wdata; // Byte in [7:0] or 16-bit command
    logic ack; // One-cycle answer
    logic ok; // Request accepted, valid with ack
    logic [7:0] rdata; // Read byte, valid with ack
    logic [2:0] irq_level; // Assigned interrupt level
    logic irq; // One-cycle interrupt event
    modport dev (input req, kind, addr, wdata, output ack, ok, rdata, irq_level, irq);
    modport host (output req, kind, addr, wdata, input ack, ok, rdata, irq_level, irq);
endinterface
`default_nettype wire

/* File: vrc_settle_timer.sv */
// Relay settling timer, restarted by every relay write
`timescale 1ns/10ps
`default_nettype none
`include "vrc_regs.svh"
module vrc_settle_timer #(
    parameter int CYCLES = `VRC_SETTLE_CYC
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic start, // Restart the interval
    output logic settled, // High once the interval has run out
    output logic fire // Pulse when the interval runs out
);
    generate
        if (CYCLES < 1) begin : g_bad
            $error("vrc_settle_timer: CYCLES must be at least 1");
        end
    endgenerate

    logic [31:0] cnt_q;

    // Down counter; a restart mid-interval extends the wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h0000_0000;
        end else if (start) begin
            cnt_q <= 32'(CYCLES);
        end else if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end

    // Settled level and end-of-interval pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settled <= 1'b1;
            fire <= 1'b0;
        end else begin
            settled <= !start && (cnt_q <= 32'h0000_0001);
            fire <= !start && (cnt_q == 32'h0000_0001);
        end
    end
endmodule
`default_nettype wire

/* File: vrc_device.sv */
// Relay control device: drive bytes, settling, substates and interrupt level
`timescale 1ns/10ps
`default_nettype none
`include "vrc_regs.svh"
// Notes on behaviour
// RULE1: every set control bit energizes its relay driver
// RULE2: host clears path bits with masks 0F, FC
// RULE3: host then sets path bits 20, 02
// RULE4: host updates images first, then writes them
// RULE5: path not settled until settling after last write
// RULE6: control bytes decoded at offsets 1,3,5,7
// RULE7: single-byte reads and writes to control bytes
// RULE8: interrupt level 0..7, zero suppresses interrupts
// RULE9: Assign Interrupter is 16-bit, configuration substate only
// RULE10: power up in configuration until Begin Normal
// RULE11: normal until Abort or End Normal Operation
// RULE12: ASCII commands only in normal substate
// RULE13: level change: Abort, Assign, then Begin
// RULE14: bit 1 closes path, bit 0 opens
// RULE15: bits numbered 0 LSB through 7 MSB
// RULE16: byte read returns last written value
module vrc_device #(
    parameter int SETTLE_CYCLES = `VRC_SETTLE_CYC
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    vrc_link_if.dev link, // Link to the host controller
    output logic [31:0] relay_drive, // Relay driver enables, byte n at [8n+7:8n]
    output logic path_settled, // Relays settled since last write
    output logic normal_op, // High in normal operation substate
    output logic [2:0] int_level, // Assigned interrupt level
    output logic ascii_valid, // Pulse with an accepted ASCII byte
    output logic [7:0] ascii_byte // Last accepted ASCII byte
);
    logic ack_q;
    logic ok_q;
    logic [7:0] rdata_q;
    logic [31:0] relay_q;
    logic normal_q;
    logic [2:0] level_q;
    logic irq_q;
    logic ascii_valid_q;
    logic [7:0] ascii_q;
    logic take;
    logic wr_hit;
    logic [2:0] dec;
    logic [7:0] opc;
    logic settled;
    logic fire;

    // Map an offset to {hit, byte index}; even and high offsets miss
    function automatic logic [2:0] decode(input logic [3:0] a);
        case (a)
            `VRC_RLY0_OFS: decode = 3'b100; // RULE6
            `VRC_RLY1_OFS: decode = 3'b101; // RULE6
            `VRC_RLY2_OFS: decode = 3'b110; // RULE6
            `VRC_RLY3_OFS: decode = 3'b111; // RULE6
            default: decode = 3'b000;
        endcase
    endfunction

    // Request taken on the first cycle it is seen without an answer pending
    assign take = link.req && !ack_q;
    assign dec = decode(link.addr);
    assign opc = link.wdata[`VRC_OPC_MSB:`VRC_OPC_LSB];
    assign wr_hit = take && (link.kind == vrc_pkg::VRC_K_WRITE) && dec[2]; // RULE7

    // Answer strobe, one cycle per request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // Acceptance flag and read data for each answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ok_q <= 1'b0;
            rdata_q <= 8'h00;
        end else if (take) begin
            rdata_q <= 8'h00;
            case (link.kind)
                vrc_pkg::VRC_K_WRITE: begin
                    ok_q <= dec[2];
                end
                vrc_pkg::VRC_K_READ: begin
                    ok_q <= dec[2];
                    if (dec[2]) begin
                        rdata_q <= relay_q[dec[1:0]*8 +: 8]; // RULE16
                    end
                end
                vrc_pkg::VRC_K_CMD: begin
                    case (opc)
                        `VRC_OPC_BEGIN_NORMAL: ok_q <= 1'b1;
                        `VRC_OPC_ABORT_NORMAL: ok_q <= 1'b1;
                        `VRC_OPC_END_NORMAL: ok_q <= 1'b1;
                        `VRC_OPC_ASSIGN_INT: ok_q <= !normal_q; // RULE9
                        `VRC_OPC_ASCII: ok_q <= normal_q; // RULE12
                        default: ok_q <= 1'b0;
                    endcase
                end
                default: ok_q <= 1'b0;
            endcase
        end
    end

    // Drive bytes: each stored bit drives its relay directly, bit 0 the LSB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_q <= {4{`VRC_RLY_RST}};
        end else if (wr_hit) begin
            relay_q[dec[1:0]*8 +: 8] <= link.wdata[7:0]; // RULE1 RULE14 RULE15
        end
    end

    // Substate: configuration after reset, normal only via Begin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_q <= 1'b0; // RULE10
        end else if (take && link.kind == vrc_pkg::VRC_K_CMD) begin
            if (opc == `VRC_OPC_BEGIN_NORMAL) begin
                normal_q <= 1'b1; // RULE10
            end else if (opc == `VRC_OPC_ABORT_NORMAL || opc == `VRC_OPC_END_NORMAL) begin
                normal_q <= 1'b0; // RULE11 RULE13
            end
        end
    end

    // Interrupt level, changed only in configuration substate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= `VRC_LVL_RST;
        end else if (take && link.kind == vrc_pkg::VRC_K_CMD && opc == `VRC_OPC_ASSIGN_INT
                     && !normal_q) begin
            level_q <= link.wdata[2:0]; // RULE8 RULE9
        end
    end

    // ASCII bytes pass on only in normal operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ascii_valid_q <= 1'b0;
            ascii_q <= 8'h00;
        end else begin
            ascii_valid_q <= take && link.kind == vrc_pkg::VRC_K_CMD
                             && opc == `VRC_OPC_ASCII && normal_q; // RULE12
            if (take && link.kind == vrc_pkg::VRC_K_CMD && opc == `VRC_OPC_ASCII && normal_q) begin
                ascii_q <= link.wdata[7:0];
            end
        end
    end

    // Settling interval restarts on every accepted relay write
    vrc_settle_timer #(
        .CYCLES(SETTLE_CYCLES)
    ) u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .start(wr_hit), // RULE5
        .settled(settled),
        .fire(fire)
    );

    // Settled event raises an interrupt unless the level is zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= fire && (level_q != 3'h0); // RULE8
        end
    end

    // Link answers and user outputs, all from flops
    assign link.ack = ack_q;
    assign link.ok = ok_q;
    assign link.rdata = rdata_q;
    assign link.irq_level = level_q;
    assign link.irq = irq_q;
    assign relay_drive = relay_q;
    assign path_settled = settled; // RULE5
    assign normal_op = normal_q;
    assign int_level = level_q;
    assign ascii_valid = ascii_valid_q;
    assign ascii_byte = ascii_q;
endmodule
`default_nettype wire

/* File: vrc_host.sv */
// Host controller: APB slave keeping relay byte images and driving the link
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "vrc_regs.svh"
module vrc_host (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic irq, // Level interrupt
    vrc_link_if.host link // Link to the device
);
    vrc_pkg::vrc_hstate_t st_q;
    logic [7:0] img_q [4];
    logic [31:0] op_q;
    logic req_q;
    vrc_pkg::vrc_kind_t kind_q;
    logic [3:0] addr_q;
    logic [15:0] wdata_q;
    logic last_ok_q;
    logic [7:0] last_rd_q;
    logic [2:0] istat_q;
    logic [2:0] imask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic acc;
    logic launch;
    logic [1:0] idx;
    logic [7:0] new_img;
    logic [2:0] ev;

    // Link offset of a drive byte index
    function automatic logic [3:0] ofs(input logic [1:0] i);
        case (i)
            2'd0: ofs = `VRC_RLY0_OFS;
            2'd1: ofs = `VRC_RLY1_OFS;
            2'd2: ofs = `VRC_RLY2_OFS;
            default: ofs = `VRC_RLY3_OFS;
        endcase
    endfunction

    // Access edge; launch only when idle and not refused in the setup cycle
    assign acc = psel && penable && pready_q;
    assign launch = acc && pwrite && paddr == `VRC_APB_OP && st_q == vrc_pkg::VRC_H_IDLE
                    && !pslverr_q;
    assign idx = pwdata[`VRC_OP_IDX_LSB +: 2];
    // Image is cleared with the and-mask, then the or-mask is set
    assign new_img = (img_q[idx] & pwdata[`VRC_OP_AND_LSB +: 8])
                     | pwdata[`VRC_OP_OR_LSB +: 8]; // RULE2 RULE3 RULE4
    assign ev = {link.irq, link.ack && !link.ok, link.ack};

    // APB answers in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= psel && !penable;
        end
    end

    // Read data and error decided in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            case (paddr)
                `VRC_APB_OP: begin
                    prdata_q <= op_q;
                    pslverr_q <= pwrite && st_q != vrc_pkg::VRC_H_IDLE;
                end
                `VRC_APB_STAT: prdata_q <= {13'h0000, link.irq_level, last_rd_q, 6'h00,
                                            last_ok_q, st_q == vrc_pkg::VRC_H_BUSY};
                `VRC_APB_ISTAT: prdata_q <= {29'h0000_0000, istat_q};
                `VRC_APB_IMASK: prdata_q <= {29'h0000_0000, imask_q};
                `VRC_APB_IMG: begin
                    prdata_q <= {img_q[3], img_q[2], img_q[1], img_q[0]};
                    pslverr_q <= pwrite;
                end
                default: pslverr_q <= 1'b1;
            endcase
        end
    end

    // Images change before the byte is sent; a read leaves them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            img_q <= '{4{`VRC_RLY_RST}};
        end else if (launch && pwdata[1:0] == 2'(vrc_pkg::VRC_K_WRITE)) begin
            img_q[idx] <= new_img; // RULE4
        end
    end

    // Sequencer: one link request at a time, held until the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= vrc_pkg::VRC_H_IDLE;
            req_q <= 1'b0;
            kind_q <= vrc_pkg::VRC_K_WRITE;
            addr_q <= 4'h0;
            wdata_q <= 16'h0000;
            op_q <= 32'h0000_0000;
        end else begin
            case (st_q)
                vrc_pkg::VRC_H_IDLE: begin
                    if (launch) begin
                        op_q <= pwdata;
                        st_q <= vrc_pkg::VRC_H_BUSY;
                        req_q <= 1'b1;
                        kind_q <= vrc_pkg::vrc_kind_t'(pwdata[1:0]);
                        addr_q <= ofs(idx); // RULE6
                        if (pwdata[1:0] == 2'(vrc_pkg::VRC_K_CMD)) begin
                            wdata_q <= pwdata[`VRC_OP_CMD_LSB +: 16]; // RULE9 RULE13
                        end else begin
                            wdata_q <= {8'h00, new_img}; // RULE7
                        end
                    end
                end
                vrc_pkg::VRC_H_BUSY: begin
                    if (link.ack) begin
                        req_q <= 1'b0;
                        st_q <= vrc_pkg::VRC_H_IDLE;
                    end
                end
                default: begin
                    st_q <= vrc_pkg::VRC_H_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // Result of the last answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ok_q <= 1'b0;
            last_rd_q <= 8'h00;
        end else if (link.ack && st_q == vrc_pkg::VRC_H_BUSY) begin
            last_ok_q <= link.ok;
            last_rd_q <= link.rdata;
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= 3'h0;
        end else if (acc && pwrite && paddr == `VRC_APB_ISTAT) begin
            istat_q <= (istat_q & ~pwdata[2:0]) | ev;
        end else begin
            istat_q <= istat_q | ev;
        end
    end

    // Mask register and interrupt level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= `VRC_IMASK_RST;
            irq_q <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == `VRC_APB_IMASK) begin
                imask_q <= pwdata[2:0];
            end
            irq_q <= |(istat_q & imask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign link.req = req_q;
    assign link.kind = kind_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
endmodule
`default_nettype wire

/* File: vrc_link_assertions.sv */
// Concurrent checks on the link between host controller and relay device
`timescale 1ns/10ps
`default_nettype none
`include "vrc_regs.svh"
module vrc_link_assertions (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic req, // Request level
    input wire vrc_pkg::vrc_kind_t kind, // Transfer kind
    input wire logic [3:0] addr, // Byte offset
    input wire logic [15:0] wdata, // Byte or command word
    input wire logic ack, // Answer pulse
    input wire logic ok, // Accepted flag
    input wire logic [7:0] rdata, // Read byte
    input wire logic [2:0] irq_level, // Assigned level
    input wire logic irq // Interrupt event
);
    logic normal_q; // Substate as implied by accepted commands
    logic [7:0] opc;
    logic is_cmd;
    logic byte_ofs;

    // Decode of the request held on the link
    assign opc = wdata[15:8];
    assign is_cmd = ack && kind == vrc_pkg::VRC_K_CMD;
    assign byte_ofs = addr inside {`VRC_RLY0_OFS, `VRC_RLY1_OFS, `VRC_RLY2_OFS, `VRC_RLY3_OFS};

    // Shadow substate, so refusals can be judged without seeing the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_q <= 1'b0;
        end else if (is_cmd && ok && opc == `VRC_OPC_BEGIN_NORMAL) begin
            normal_q <= 1'b1;
        end else if (is_cmd && ok && opc inside {`VRC_OPC_ABORT_NORMAL, `VRC_OPC_END_NORMAL}) begin
            normal_q <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Request taken, then a single answer cycle
    sequence s_taken;
        req && !ack;
    endsequence
    sequence s_answer;
        ack ##1 !ack;
    endsequence

    a_ack_after_take: assert property (s_taken |=> s_answer)
        else $error("link answer missing or not one cycle");
    a_ack_needs_req: assert property (ack |-> req && $past(req))
        else $error("answer without a held request");
    a_byte_ofs_decode: assert property (ack && kind inside {vrc_pkg::VRC_K_WRITE,
            vrc_pkg::VRC_K_READ} |-> ok == byte_ofs)
        else $error("byte offset decode wrong");
    a_rdata_quiet: assert property (ack && kind != vrc_pkg::VRC_K_READ |-> rdata == 8'h00)
        else $error("read byte not zero outside reads");
    a_bad_kind_refused: assert property (ack && kind == vrc_pkg::vrc_kind_t'(2'b11) |-> !ok)
        else $error("unknown kind accepted");
    a_assign_config: assert property (is_cmd && opc == `VRC_OPC_ASSIGN_INT |-> ok == !normal_q)
        else $error("assign accepted outside configuration");
    a_ascii_normal: assert property (is_cmd && opc == `VRC_OPC_ASCII |-> ok == normal_q)
        else $error("ascii accepted outside normal operation");
    a_mode_cmds_ok: assert property (is_cmd && opc inside {`VRC_OPC_BEGIN_NORMAL,
            `VRC_OPC_ABORT_NORMAL, `VRC_OPC_END_NORMAL} |-> ok)
        else $error("substate command refused");
    a_level_cause: assert property ($changed(irq_level) |-> is_cmd && ok
            && opc == `VRC_OPC_ASSIGN_INT && irq_level == wdata[2:0])
        else $error("level changed without accepted assign");
    a_irq_level_gate: assert property (irq |-> (irq_level != 3'h0) ##1 !irq)
        else $error("interrupt at level zero or longer than one cycle");
endmodule
`default_nettype wire

/* File: vxi_relay_control_regs_tb.sv */
// Self-checking bench for the relay control host, link and device
`timescale 1ns/10ps
`default_nettype none
`include "vrc_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module vxi_relay_control_regs_tb;
    localparam int SC = 4; // Short settling keeps the run brief
    // Command table: opcode, argument, ok [12], normal [8], ascii count [7:4], level [2:0]
    localparam logic [31:0] CMDS [13] = '{32'hA541_0000, 32'hA405_1005, 32'hA100_1105,
        32'hA402_0105, 32'hA543_1115, 32'hA100_1115, 32'hA200_1015, 32'hA403_1013,
        32'hA100_1113, 32'hA300_1013, 32'hA200_1013, 32'hA700_0013, 32'hA100_1113};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, relay_drive;
    logic pready, pslverr, irq, err, normal_op, path_settled, ascii_valid;
    logic [2:0] int_level;
    logic [7:0] ascii_byte;
    logic [7:0] img [4];
    int fails = 0;
    int checks = 0;
    int asc_cnt = 0;
    int seed = 32'h0000_c808;
    int n;

    vrc_link_if link ();
    vrc_host vrc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link.host));
    vrc_device #(.SETTLE_CYCLES(SC)) vrc_device_inst (.pclk(pclk), .presetn(presetn),
        .link(link.dev), .relay_drive(relay_drive), .path_settled(path_settled),
        .normal_op(normal_op), .int_level(int_level), .ascii_valid(ascii_valid),
        .ascii_byte(ascii_byte));
    vrc_link_assertions vrc_link_assertions_inst (.pclk(pclk), .presetn(presetn),
        .req(link.req), .kind(link.kind), .addr(link.addr), .wdata(link.wdata),
        .ack(link.ack), .ok(link.ok), .rdata(link.rdata), .irq_level(link.irq_level),
        .irq(link.irq));

    // Clock and ascii pulse tally
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) if (ascii_valid === 1'b1) asc_cnt++;

    // Expected image after a mask-then-set update
    function automatic logic [7:0] upd(input logic [7:0] o, input logic [7:0] a,
            input logic [7:0] m);
        return (o & a) | m;
    endfunction

    // One APB transfer; an idle edge after it avoids re-driving psel in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Launch one link operation and check its outcome
    task automatic op(input logic [1:0] kd, input logic [1:0] ix, input logic [7:0] am,
            input logic [7:0] om, input logic [15:0] cw, input logic exp_ok);
        int k;
        k = 0;
        apb(1'b1, `VRC_APB_OP, kd == 2'b10 ? {cw, 12'h000, ix, kd} : {8'h00, om, am, 4'h0, ix, kd});
        do begin
            @(posedge pclk);
            k++;
        end while (link.ack !== 1'b1 && k < 20);
        if (k >= 20) fails++;
        `CHK(link.ok, exp_ok)
        if (kd == 2'b00) begin
            img[ix] = upd(img[ix], am, om);
            k = 0;
            while (path_settled !== 1'b1 && k < 50) begin
                @(posedge pclk);
                k++;
            end
            `CHK(k >= SC - 1 && k <= SC + 1, 1'b1)
            `CHK(relay_drive, {img[3], img[2], img[1], img[0]})
        end
        apb(1'b0, `VRC_APB_STAT, 32'h0000_0000);
        `CHK(rd[1:0], {exp_ok, 1'b0})
        if (kd == 2'b01) `CHK(rd[15:8], img[ix])
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        img = '{default: 8'h00};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK({normal_op, path_settled, int_level, relay_drive}, {2'b01, 3'h0, 32'h0})
        apb(1'b0, `VRC_APB_STAT, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        $display("test reset done");
        foreach (CMDS[i]) begin
            op(2'b10, 2'b00, 8'h00, 8'h00, CMDS[i][31:16], CMDS[i][12]);
            `CHK({normal_op, int_level}, {CMDS[i][8], CMDS[i][2:0]})
            `CHK(asc_cnt[3:0], CMDS[i][7:4])
            `CHK(rd[18:16], CMDS[i][2:0])
        end
        `CHK(ascii_byte, 8'h43)
        $display("test substates done");
        // Two-register path over stale bits
        op(2'b00, 2'd1, 8'h00, 8'hFF, 16'h0000, 1'b1);
        op(2'b00, 2'd2, 8'h00, 8'hFF, 16'h0000, 1'b1);
        op(2'b00, 2'd1, 8'h0F, 8'h20, 16'h0000, 1'b1);
        op(2'b00, 2'd2, 8'hFC, 8'h02, 16'h0000, 1'b1);
        `CHK(relay_drive[23:8], 16'hFE2F)
        apb(1'b0, `VRC_APB_IMG, 32'h0000_0000);
        `CHK(rd, {img[3], img[2], img[1], img[0]})
        $display("test path done");
        // Settle event raises, clears and is masked
        apb(1'b1, `VRC_APB_ISTAT, 32'h0000_0007);
        apb(1'b1, `VRC_APB_IMASK, 32'h0000_0004);
        op(2'b00, 2'd0, 8'hFF, 8'h01, 16'h0000, 1'b1);
        apb(1'b0, `VRC_APB_ISTAT, 32'h0000_0000);
        `CHK({rd[2:0], irq}, 4'b1011)
        apb(1'b1, `VRC_APB_ISTAT, 32'h0000_0004);
        apb(1'b0, `VRC_APB_ISTAT, 32'h0000_0000);
        `CHK({rd[2:0], irq}, 4'b0010)
        apb(1'b1, `VRC_APB_IMASK, 32'h0000_0000);
        op(2'b00, 2'd0, 8'hFF, 8'h80, 16'h0000, 1'b1);
        apb(1'b0, `VRC_APB_ISTAT, 32'h0000_0000);
        `CHK({rd[2], irq}, 2'b10)
        // Level zero suppresses the event
        op(2'b10, 2'b00, 8'h00, 8'h00, {`VRC_OPC_ABORT_NORMAL, 8'h00}, 1'b1);
        op(2'b10, 2'b00, 8'h00, 8'h00, {`VRC_OPC_ASSIGN_INT, 8'h00}, 1'b1);
        apb(1'b1, `VRC_APB_ISTAT, 32'h0000_0007);
        op(2'b00, 2'd3, 8'h00, 8'h5A, 16'h0000, 1'b1);
        apb(1'b0, `VRC_APB_ISTAT, 32'h0000_0000);
        `CHK(rd[2], 1'b0)
        $display("test interrupt done");
        // Refusals: busy OP, bad kind, unmapped address, read-only image
        apb(1'b1, `VRC_APB_OP, 32'h0000_0001);
        apb(1'b1, `VRC_APB_OP, 32'h0000_0003);
        `CHK(err, 1'b1)
        apb(1'b0, `VRC_APB_OP, 32'h0000_0000);
        `CHK(rd, 32'h0000_0001)
        op(2'b11, 2'd0, 8'h00, 8'h00, 16'h0000, 1'b0);
        apb(1'b0, `VRC_APB_ISTAT, 32'h0000_0000);
        `CHK(rd[1], 1'b1)
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        apb(1'b1, `VRC_APB_IMG, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        apb(1'b0, `VRC_APB_IMG, 32'h0000_0000);
        `CHK(rd, {img[3], img[2], img[1], img[0]})
        $display("test refusals done");
        // Random updates with read-back
        repeat (16) begin
            n = $random(seed);
            op(2'b00, n[1:0], n[15:8], n[23:16], 16'h0000, 1'b1);
            op(2'b01, n[3:2], 8'h00, 8'h00, 16'h0000, 1'b1);
        end
        $display("test random done");
        wrap_up();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #50000;
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
